/* File: design/global_chip_control_reg.sv */
// Device-wide chip control register on the configuration access port.
// Assumes sys_rst is the fundamental reset and hotReset any other reset.
`timescale 1ns/10ps
module global_chip_control_reg
  import chip_control_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        hotReset,
  input  wire logic        cfgWrite,
  input  wire logic        cfgRead,
  input  wire logic [11:0] cfgAddr,
  input  wire logic [3:0]  cfgByteEnable,
  input  wire logic [31:0] cfgWriteData,
  output logic [31:0]      cfgReadData,
  output logic             cfgReadValid,
  input  wire logic        eepromLoad,
  input  wire logic [31:0] eepromData,
  input  wire logic        linkInL1,
  input  wire logic        l1ByDevicePower,
  input  wire logic        slotLimitLoad,
  input  wire logic [7:0]  slotLimitValue,
  input  wire logic [1:0]  slotLimitScale,
  output logic             l1PllShutoffSelect,
  output logic             activeL1Permit,
  output logic             linkCapL1Support,
  output logic             pllShutoff,
  output logic             diagnosticBit,
  output logic [1:0]       minPowerScale,
  output logic [7:0]       minPowerValue,
  output logic             powerOverLimit
);

  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [31:0] next_cfgReadData;
  logic        next_cfgReadValid;
  logic        next_pllShutoff;
  logic        hitWrite;
  logic        hitRead;

  // Address match, shared by the write and read decode
  function automatic logic atCtrlOffset(input logic [11:0] addr);
    atCtrlOffset = (addr == CTRL_OFFSET);
  endfunction : atCtrlOffset

  // Only the single register offset hits; reads at other offsets still answer with zeros
  assign hitWrite = cfgWrite && atCtrlOffset(cfgAddr);
  assign hitRead  = cfgRead && atCtrlOffset(cfgAddr);

  // Storage: EEPROM image first, software byte writes on top of it.
  // Only writable bits are kept, so reserved bits can never hold a one.
  always_comb begin
    next_ctrl = ctrl;
    if (eepromLoad) begin
      next_ctrl = eepromData & CTRL_RW_MASK;
    end
    if (hitWrite) begin
      for (int i = 0; i < 4; i++) begin
        if (cfgByteEnable[i]) begin
          next_ctrl[8*i +: 8] = cfgWriteData[8*i +: 8];
        end
      end
    end
    next_ctrl = next_ctrl & CTRL_RW_MASK;
  end

  // Only the fundamental reset clears the fields; hotReset is ignored here
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl <= CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Read port: one cycle latency, zeros for unmapped offsets
  always_comb begin
    next_cfgReadValid = cfgRead;
    next_cfgReadData  = UNMAPPED_READ;
    if (hitRead) begin
      next_cfgReadData = ctrl & CTRL_RW_MASK;
    end
  end

  // Read answer restarts on any reset; no transfer spans one
  always_ff @(posedge clock) begin
    if (sys_rst || hotReset) begin
      cfgReadData  <= 32'h0000_0000;
      cfgReadValid <= 1'b0;
    end else begin
      cfgReadData  <= next_cfgReadData;
      cfgReadValid <= next_cfgReadValid;
    end
  end

  // PLL control: device power L1 always stops, active L1 follows bit 30
  always_comb begin
    next_pllShutoff = linkInL1 &&
      (l1ByDevicePower || ctrl[PLL_SELECT_BIT]);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pllShutoff <= 1'b0;
    end else begin
      pllShutoff <= next_pllShutoff;
    end
  end

  // Field views for the link logic
  assign l1PllShutoffSelect = ctrl[PLL_SELECT_BIT];
  assign activeL1Permit     = ctrl[L1_PERMIT_BIT];
  assign linkCapL1Support   = ctrl[L1_PERMIT_BIT];
  assign diagnosticBit      = ctrl[DIAG_BIT];        // Must stay zero
  assign minPowerScale      = ctrl[SCALE_LSB +: 2];
  assign minPowerValue      = ctrl[VALUE_LSB +: 8];

  // Required power against the received limit
  min_power_check min_power_check_inst (
    .clock          (clock),
    .sys_rst        (sys_rst),
    .minPowerValue  (minPowerValue),
    .minPowerScale  (minPowerScale),
    .slotLimitLoad  (slotLimitLoad),
    .slotLimitValue (slotLimitValue),
    .slotLimitScale (slotLimitScale),
    .powerOverLimit (powerOverLimit)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  readBack_a : assert property (
    hitRead && !hotReset |=> cfgReadValid && cfgReadData == $past(ctrl))
    else $error("read at control offset returned wrong data");

  stickyHot_a : assert property (
    hotReset && !cfgWrite && !eepromLoad |=> $stable(ctrl))
    else $error("control contents changed on a non-fundamental reset");

  topBitZero_a : assert property (
    cfgReadValid |-> !cfgReadData[31])
    else $error("reserved bit 31 read as one");

  activePll_a : assert property (
    linkInL1 && !l1ByDevicePower |=> pllShutoff == $past(ctrl[PLL_SELECT_BIT]))
    else $error("PLL state does not follow select bit in active L1");

  devicePll_a : assert property (
    linkInL1 && l1ByDevicePower ##1 1'b1 |-> pllShutoff)
    else $error("PLL kept running in device power L1");

  capSupport_a : assert property (
    hitWrite && cfgByteEnable[3] |=>
      linkCapL1Support == $past(cfgWriteData[L1_PERMIT_BIT]))
    else $error("advertised L1 support does not follow write");

  midZero_a : assert property (
    cfgReadValid |-> cfgReadData[27:22] == 6'h00)
    else $error("reserved bits 27 to 22 read nonzero");

  scaleWrite_a : assert property (
    hitWrite && cfgByteEnable[2] |=>
      minPowerScale == $past(cfgWriteData[21:20]))
    else $error("power scale not stored from write");

  eepromLoad_a : assert property (
    eepromLoad && !hitWrite |=> ctrl == ($past(eepromData) & CTRL_RW_MASK))
    else $error("EEPROM image not loaded");

  resetClear_a : assert property (
    $past(sys_rst) |-> ctrl == CTRL_RESET)
    else $error("fields not cleared by fundamental reset");

  roIgnore_a : assert property (
    hitWrite ##1 1'b1 |-> (ctrl & ~CTRL_RW_MASK) == 32'h0000_0000)
    else $error("read-only bits took a written value");

  readIdle_a : assert property (
    !cfgRead |=> !cfgReadValid && cfgReadData == 32'h0000_0000)
    else $error("read answer present without a read");

  unmappedRead_a : assert property (
    cfgRead && !hitRead && !hotReset |=>
      cfgReadValid && cfgReadData == UNMAPPED_READ)
    else $error("unmapped read did not answer zero");

  hotClear_a : assert property (
    hotReset |=> !cfgReadValid && cfgReadData == 32'h0000_0000)
    else $error("read answer survived a non-fundamental reset");

  holdValue_a : assert property (
    !hitWrite && !eepromLoad |=> $stable(ctrl))
    else $error("control contents changed without a write or load");

  pllSelect_a : assert property (
    hitWrite && cfgByteEnable[3] |=>
      l1PllShutoffSelect == $past(cfgWriteData[PLL_SELECT_BIT]))
    else $error("PLL select bit not stored from write");

  pllIdle_a : assert property (
    !linkInL1 |=> !pllShutoff)
    else $error("PLLs stopped outside L1");

  permitWrite_a : assert property (
    hitWrite && cfgByteEnable[3] |=>
      activeL1Permit == $past(cfgWriteData[L1_PERMIT_BIT]))
    else $error("active L1 permit not stored from write");

  valueWrite_a : assert property (
    hitWrite && cfgByteEnable[1] |=>
      minPowerValue[3:0] == $past(cfgWriteData[15:12]))
    else $error("minimum power value not stored from write");

endmodule : global_chip_control_reg

/* File: design/chip_control_pkg.sv */
// Constants for the device-wide chip control register.
// Assumes one 100 MHz clock and a byte-addressed configuration port.
package chip_control_pkg;

  // Configuration byte offset of the register
  localparam logic [11:0] CTRL_OFFSET     = 12'h0B8;
  // Contents after the fundamental reset
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  // Bits that software and the EEPROM may store
  localparam logic [31:0] CTRL_RW_MASK    = 32'h703F_F000;

  // Field positions
  localparam int          PLL_SELECT_BIT  = 30;
  localparam int          L1_PERMIT_BIT   = 29;
  localparam int          DIAG_BIT        = 28;
  localparam int          SCALE_LSB       = 20;
  localparam int          VALUE_LSB       = 12;

  // Power scale codes turned into milliwatt multipliers
  localparam logic [17:0] MW_SCALE_1      = 18'h003E8;
  localparam logic [17:0] MW_SCALE_0P1    = 18'h00064;
  localparam logic [17:0] MW_SCALE_0P01   = 18'h0000A;
  localparam logic [17:0] MW_SCALE_0P001  = 18'h00001;

  // Read answer for unmapped offsets
  localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;

endpackage : chip_control_pkg

/* File: design/min_power_check.sv */
// Slot power check: required minimum power against the received limit.
// Assumes the limit arrives as a one-cycle load pulse with value and scale.
`timescale 1ns/10ps
module min_power_check
  import chip_control_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] minPowerValue,
  input  wire logic [1:0] minPowerScale,
  input  wire logic       slotLimitLoad,
  input  wire logic [7:0] slotLimitValue,
  input  wire logic [1:0] slotLimitScale,
  output logic            powerOverLimit
);

  // Value times scale in milliwatts; 255 W fits in 18 bits
  function automatic logic [17:0] toMilliwatt(input logic [7:0] value,
                                              input logic [1:0] scale);
    logic [17:0] factor;
    case (scale)
      2'h0:    factor = MW_SCALE_1;
      2'h1:    factor = MW_SCALE_0P1;
      2'h2:    factor = MW_SCALE_0P01;
      default: factor = MW_SCALE_0P001;
    endcase
    toMilliwatt = 18'(18'(value) * factor);
  endfunction : toMilliwatt

  logic [7:0]  limitValue;
  logic [1:0]  limitScale;
  logic        limitSeen;
  logic [7:0]  next_limitValue;
  logic [1:0]  next_limitScale;
  logic        next_limitSeen;
  logic        next_powerOverLimit;

  // Latch the last limit message; a zero minimum power value disables the check
  always_comb begin
    next_limitValue = limitValue;
    next_limitScale = limitScale;
    next_limitSeen  = limitSeen;
    if (slotLimitLoad) begin
      next_limitValue = slotLimitValue;
      next_limitScale = slotLimitScale;
      next_limitSeen  = 1'b1;
    end
    next_powerOverLimit = (minPowerValue != 8'h00) && limitSeen &&
      (toMilliwatt(minPowerValue, minPowerScale) >
       toMilliwatt(limitValue, limitScale));
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      limitValue     <= 8'h00;
      limitScale     <= 2'h0;
      limitSeen      <= 1'b0;
      powerOverLimit <= 1'b0;
    end else begin
      limitValue     <= next_limitValue;
      limitScale     <= next_limitScale;
      limitSeen      <= next_limitSeen;
      powerOverLimit <= next_powerOverLimit;
    end
  end

  zeroValueQuiet_a : assert property (@(posedge clock) disable iff (sys_rst)
    minPowerValue == 8'h00 |=> !powerOverLimit)
    else $error("power flag raised with zero minimum value");

endmodule : min_power_check

/* File: tb/tb.sv */
// Self-checking bench for the device-wide chip control register.
// Assumes synchronous active-high resets and inputs driven on falling edges.
`timescale 1ns/10ps
module tb;
  import chip_control_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hotReset = 1'b0;
  logic        cfgWrite = 1'b0;
  logic        cfgRead = 1'b0;
  logic [11:0] cfgAddr = 12'h000;
  logic [3:0]  cfgByteEnable = 4'h0;
  logic [31:0] cfgWriteData = 32'h0000_0000;
  logic [31:0] cfgReadData;
  logic        cfgReadValid;
  logic        eepromLoad = 1'b0;
  logic [31:0] eepromData = 32'h0000_0000;
  logic        linkInL1 = 1'b0;
  logic        l1ByDevicePower = 1'b0;
  logic        slotLimitLoad = 1'b0;
  logic [7:0]  slotLimitValue = 8'h00;
  logic [1:0]  slotLimitScale = 2'h0;
  logic        l1PllShutoffSelect, activeL1Permit, linkCapL1Support;
  logic        pllShutoff, diagnosticBit, powerOverLimit;
  logic [1:0]  minPowerScale;
  logic [7:0]  minPowerValue;
  int          nErrors = 0;
  int          numChecks = 0;

  global_chip_control_reg global_chip_control_reg_inst (
    .clock(clock), .sys_rst(sys_rst), .hotReset(hotReset),
    .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
    .cfgByteEnable(cfgByteEnable), .cfgWriteData(cfgWriteData),
    .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid),
    .eepromLoad(eepromLoad), .eepromData(eepromData),
    .linkInL1(linkInL1), .l1ByDevicePower(l1ByDevicePower),
    .slotLimitLoad(slotLimitLoad), .slotLimitValue(slotLimitValue),
    .slotLimitScale(slotLimitScale),
    .l1PllShutoffSelect(l1PllShutoffSelect),
    .activeL1Permit(activeL1Permit), .linkCapL1Support(linkCapL1Support),
    .pllShutoff(pllShutoff), .diagnosticBit(diagnosticBit),
    .minPowerScale(minPowerScale), .minPowerValue(minPowerValue),
    .powerOverLimit(powerOverLimit));

  // Free-running 100 MHz clock
  always #5 clock = ~clock;

  // Verdict and end of run
  task automatic wrapUp;
    if (nErrors == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrapUp

  // Case equality so an unknown never counts as a match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe, taken at the rising edge between two falls
  task automatic wr(input logic [11:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(negedge clock);
    cfgWrite = 1'b1; cfgAddr = a; cfgByteEnable = be; cfgWriteData = d;
    @(negedge clock);
    cfgWrite = 1'b0;
  endtask : wr

  // Read answer stands exactly one cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clock);
    cfgRead = 1'b1; cfgAddr = a;
    @(negedge clock);
    cfgRead = 1'b0;
    chk({31'h0, cfgReadValid}, 32'h1);
    chk(cfgReadData, exp);
    @(negedge clock);
    chk({31'h0, cfgReadValid}, 32'h0);
  endtask : rd

  // PLL output is registered, so look one cycle after the inputs move
  task automatic pll(input logic inL1, input logic dev, input logic exp);
    @(negedge clock);
    linkInL1 = inL1; l1ByDevicePower = dev;
    @(negedge clock);
    chk({31'h0, pllShutoff}, {31'h0, exp});
  endtask : pll

  // Program value and scale, send one limit message, flag two edges later
  task automatic pwr(input logic [7:0] v, input logic [1:0] s,
                     input logic [7:0] lv, input logic [1:0] ls,
                     input logic exp);
    wr(CTRL_OFFSET, 4'hF, {10'h000, s, v, 12'h000});
    @(negedge clock);
    slotLimitLoad = 1'b1; slotLimitValue = lv; slotLimitScale = ls;
    @(negedge clock);
    slotLimitLoad = 1'b0;
    repeat (2) @(negedge clock);
    chk({31'h0, powerOverLimit}, {31'h0, exp});
  endtask : pwr

  // Main sequence; bit 28 is never set by the bench
  initial begin
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    rd(CTRL_OFFSET, 32'h0000_0000);
    rd(12'h0B4, 32'h0000_0000);
    wr(CTRL_OFFSET, 4'hF, 32'hEFFF_FFFF);
    rd(CTRL_OFFSET, 32'h603F_F000);
    chk({18'h0, l1PllShutoffSelect, activeL1Permit, linkCapL1Support,
         diagnosticBit, minPowerScale, minPowerValue}, 32'h3BFF);
    wr(12'h0BC, 4'hF, 32'h0000_0000);
    rd(CTRL_OFFSET, 32'h603F_F000);
    wr(CTRL_OFFSET, 4'h8, 32'h0000_0000);
    rd(CTRL_OFFSET, 32'h003F_F000);
    @(negedge clock);
    hotReset = 1'b1;
    @(negedge clock);
    hotReset = 1'b0;
    rd(CTRL_OFFSET, 32'h003F_F000);
    wr(CTRL_OFFSET, 4'hF, 32'h0000_0000);
    pll(1'b1, 1'b0, 1'b0);
    pll(1'b1, 1'b1, 1'b1);
    pll(1'b0, 1'b1, 1'b0);
    wr(CTRL_OFFSET, 4'hF, 32'h4000_0000);
    pll(1'b1, 1'b0, 1'b1);
    pll(1'b0, 1'b0, 1'b0);
    // Every scale code on both sides of the strict comparison
    for (int s = 0; s < 4; s++) begin
      pwr(8'h02, s[1:0], 8'h01, s[1:0], 1'b1);
      pwr(8'h02, s[1:0], 8'h02, s[1:0], 1'b0);
    end
    pwr(8'h0A, 2'h1, 8'h01, 2'h0, 1'b0);
    pwr(8'h0B, 2'h1, 8'h01, 2'h0, 1'b1);
    pwr(8'h00, 2'h0, 8'h00, 2'h3, 1'b0);
    @(negedge clock);
    sys_rst = 1'b1;
    @(negedge clock);
    sys_rst = 1'b0;
    rd(CTRL_OFFSET, 32'h0000_0000);
    @(negedge clock);
    eepromLoad = 1'b1; eepromData = 32'hAFFF_FFFF;
    @(negedge clock);
    eepromLoad = 1'b0;
    rd(CTRL_OFFSET, 32'h203F_F000);
    wrapUp();
  end
endmodule : tb
